// File: hw/vic_pkg.sv
package vic_pkg;
  localparam int unsigned NUM_SRC        = 23;
  localparam int unsigned ID_W           = 5;
  localparam logic [7:0]  GLOBAL_EN_BIT  = 8'h07;
  localparam int unsigned FIRST_VEC      = 3;
  localparam int unsigned VEC_STEP       = 8;
  localparam logic [15:0] RESET_VEC      = 16'h0000;
  localparam logic [22:0] HW_CLEAR_MASK  = 23'h01000F;
  localparam logic [31:0] APB_IRQ_ENA    = 32'h0000_0000;
  localparam logic [31:0] APB_IRQ_PRIO   = 32'h0000_0004;
  localparam logic [31:0] APB_PEND       = 32'h0000_0008;
  localparam logic [31:0] APB_STATUS     = 32'h0000_000C;
  localparam logic [31:0] APB_SUM_STAT   = 32'h0000_0010;
  localparam logic [31:0] APB_SUM_CLR    = 32'h0000_0014;
  localparam logic [31:0] APB_SUM_EN     = 32'h0000_0018;
  localparam logic [22:0] PRIO_RESET     = 23'h000000;
  localparam logic [23:0] ENA_RESET      = 24'h000000;
  localparam int unsigned CALL_CYCLES    = 4;
  localparam int unsigned DETECT_CYCLES  = 1;
  localparam logic [1:0]  EV_TAKEN       = 2'h0;
  localparam logic [1:0]  EV_RETURN      = 2'h1;

  typedef struct packed {
    logic        valid;
    logic        high;
    logic [4:0]  id;
    logic [15:0] vector;
  } vic_req_t;

  typedef struct packed {
    logic ack;
    logic ret;
    logic instr_done;
  } vic_core_t;

  typedef enum logic [1:0] {
    VIC_IDLE  = 2'b00,
    VIC_LOW   = 2'b01,
    VIC_HIGH  = 2'b10,
    VIC_NEST  = 2'b11
  } vic_lvl_t;
endpackage

// File: hw/vic_ctrl.sv
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - Twenty-three sources, each low or high priority
// - Flag sets regardless of any enable
// - Request after instruction ends, call fixed vector
// - Global enable gates every source enable
// - Disabled pending flag raises no request
// - Clear takes effect before following multi-cycle instruction
// - Some flags self-clear when vectored
// - Flag still set after return requests again
// - Software write of one acts as event
// - High preempts low; high never preempted
// - Higher level first, fixed order ties
// - Lower order wins; reset above all
// - Vectors from 0x0003 stepping by eight
// - Sampled each clock; one detect, four call
// - After return, one instruction before call
// - Worst case eighteen cycles via return, divide
// - Equal or lower waits for return plus one
// - Main enable reg at 0xA8, resets zero
module vic_ctrl #(
  parameter int unsigned NSRC = vic_pkg::NUM_SRC
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [NSRC-1:0]      src_event,
  input  wire logic                 instr_done,
  input  wire logic                 core_ack,
  input  wire logic                 core_interrupt_return,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  output vic_pkg::vic_req_t         irq_req,
  output logic                      irq
);
  initial
  begin
    if (NSRC != vic_pkg::NUM_SRC)
      $error("source count must match the vector map");
    if (vic_pkg::ID_W < $clog2(NSRC))
      $error("source id field too narrow for the source count");
    if (NSRC > 23)
      $error("enable word holds at most 23 sources below the global bit");
  end

  logic [23:0]         ena_reg;
  logic [NSRC-1:0]     prio_reg;
  logic [NSRC-1:0]     pend_reg;
  vic_pkg::vic_lvl_t   lvl_reg;
  vic_pkg::vic_lvl_t   lvl_next;
  logic                after_ret_reg;
  logic                gate_reg;
  logic [NSRC-1:0]     sum_stat_reg;
  logic [NSRC-1:0]     sum_en_reg;
  logic [NSRC-1:0]     pend_next;
  logic [NSRC-1:0]     active;
  logic [NSRC-1:0]     new_evt;
  logic [NSRC-1:0]     hw_clr;
  logic                wr;
  logic                wr_ena;
  logic                wr_prio;
  logic                wr_pend;
  logic                wr_sclr;
  logic                wr_sen;
  logic                taken;
  logic                glob_en;
  logic                sum_hit;
  logic                setup;
  logic [4:0]          win_id;
  logic                win_hi;
  logic                win_ok;
  logic [31:0]         rd_word;
  logic                rd_err;
  vic_pkg::vic_req_t   req_next;

  assign wr = psel && penable && pwrite;

  function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] off);
    // Whole-word match; byte lanes are not decoded
    reg_hit = (a == off);
  endfunction

  // Write strobes fire in the access phase only
  assign wr_ena  = wr && reg_hit(paddr, vic_pkg::APB_IRQ_ENA);
  assign wr_prio = wr && reg_hit(paddr, vic_pkg::APB_IRQ_PRIO);
  assign wr_pend = wr && reg_hit(paddr, vic_pkg::APB_PEND);
  assign wr_sclr = wr && reg_hit(paddr, vic_pkg::APB_SUM_CLR);
  assign wr_sen  = wr && reg_hit(paddr, vic_pkg::APB_SUM_EN);
  assign taken   = core_ack && irq_req.valid;
  assign glob_en = ena_reg[23];
  // Only flags that were clear count as new summary events
  assign new_evt = src_event & ~pend_reg;
  // Only the served source may self-clear, and only if its kind does
  assign hw_clr  = vic_pkg::HW_CLEAR_MASK & (NSRC'(1) << irq_req.id);

  function automatic logic [15:0] vec_of(input logic [4:0] id);
    vec_of = 16'(vic_pkg::FIRST_VEC + vic_pkg::VEC_STEP * int'(id));
  endfunction

  assign active = pend_reg & ena_reg[NSRC-1:0] & {NSRC{glob_en}};

  always_comb
  begin
    win_id = 5'h00;
    win_hi = 1'b0;
    win_ok = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (active[i] && !prio_reg[i] && !win_hi)
      begin
        win_id = 5'(i);
        win_ok = 1'b1;
      end
    end
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (active[i] && prio_reg[i])
      begin
        win_id = 5'(i);
        win_hi = 1'b1;
        win_ok = 1'b1;
      end
    end
  end

  // set on event, set beats clear
  always_comb
  begin
    pend_next = pend_reg;
    if (wr_pend)
      pend_next = pwdata[NSRC-1:0];
    if (taken)
      pend_next = pend_next & ~hw_clr;
    pend_next = pend_next | src_event;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pend_reg <= '0;
    else
      pend_reg <= pend_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ena_reg <= vic_pkg::ENA_RESET;
    else if (wr_ena)
      ena_reg <= pwdata[23:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prio_reg <= vic_pkg::PRIO_RESET;
    else if (wr_prio)
      prio_reg <= pwdata[NSRC-1:0];
  end

  always_comb
  begin
    lvl_next = lvl_reg;
    if (taken)
    begin
      unique case (lvl_reg)
        vic_pkg::VIC_IDLE: lvl_next = irq_req.high ? vic_pkg::VIC_HIGH : vic_pkg::VIC_LOW;
        vic_pkg::VIC_LOW:  lvl_next = irq_req.high ? vic_pkg::VIC_NEST : vic_pkg::VIC_LOW;
        vic_pkg::VIC_HIGH: lvl_next = vic_pkg::VIC_HIGH;
        vic_pkg::VIC_NEST: lvl_next = vic_pkg::VIC_NEST;
      endcase
    end
    else if (core_interrupt_return)
    begin
      // High returns first, so a nested pair unwinds to low
      unique case (lvl_reg)
        vic_pkg::VIC_IDLE: lvl_next = vic_pkg::VIC_IDLE;
        vic_pkg::VIC_LOW:  lvl_next = vic_pkg::VIC_IDLE;
        vic_pkg::VIC_HIGH: lvl_next = vic_pkg::VIC_IDLE;
        vic_pkg::VIC_NEST: lvl_next = vic_pkg::VIC_LOW;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      lvl_reg <= vic_pkg::VIC_IDLE;
    else
      lvl_reg <= lvl_next;
  end

  // waits for return and one more
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      after_ret_reg <= 1'b0;
    else if (core_interrupt_return)
      after_ret_reg <= 1'b1;
    else if (instr_done)
      after_ret_reg <= 1'b0;
  end

  // decoded every clock, one detect cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gate_reg <= 1'b0;
    else
      gate_reg <= win_ok && !after_ret_reg && !core_interrupt_return
                  && (lvl_reg == vic_pkg::VIC_IDLE || (win_hi && lvl_reg == vic_pkg::VIC_LOW));
  end

  always_comb
  begin
    req_next = irq_req;
    if (core_ack)
      req_next = '0;
    // A posted request stands unchanged until the core takes it
    else if (!irq_req.valid && instr_done && gate_reg && win_ok)
    begin
      req_next.valid  = 1'b1;
      req_next.high   = win_hi;
      req_next.id     = win_id;
      req_next.vector = vec_of(win_id);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_req <= '0;
    else
      irq_req <= req_next;
  end

  // summary status per source
  // Set wins over the write-one clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sum_stat_reg <= '0;
    else if (wr_sclr)
      sum_stat_reg <= (sum_stat_reg & ~pwdata[NSRC-1:0]) | new_evt;
    else
      sum_stat_reg <= sum_stat_reg | new_evt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sum_en_reg <= '0;
    else if (wr_sen)
      sum_en_reg <= pwdata[NSRC-1:0];
  end

  assign sum_hit = |(sum_stat_reg & sum_en_reg);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= sum_hit;
  end

  // Read word decoded in setup, so the access phase needs no wait state
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (paddr)
      vic_pkg::APB_IRQ_ENA:  rd_word = {8'h00, ena_reg};
      vic_pkg::APB_IRQ_PRIO: rd_word = {9'h000, prio_reg};
      vic_pkg::APB_PEND:     rd_word = {9'h000, pend_reg};
      vic_pkg::APB_STATUS:   rd_word = {24'h000000, 1'b0, win_ok, win_hi, win_id};
      vic_pkg::APB_SUM_STAT: rd_word = {9'h000, sum_stat_reg};
      vic_pkg::APB_SUM_EN:   rd_word = {9'h000, sum_en_reg};
      vic_pkg::APB_SUM_CLR:  rd_word = 32'h0000_0000;
      default:               rd_err  = 1'b1;
    endcase
  end

  assign setup = psel && !penable;

  // Zero-wait slave: ready in every first access cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // Unmapped offsets answer with an error and read zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup && rd_err;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else
      prdata <= setup ? rd_word : 32'h0000_0000;
  end
endmodule

// File: bench/vic_asserts.sv
`timescale 1ns/1ps
module vic_asserts (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              instr_done,
  input wire logic              core_ack,
  input wire logic              core_interrupt_return,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire vic_pkg::vic_req_t irq_req,
  input wire logic              irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_ACK_DROP: assert property (core_ack |=> !irq_req.valid)
    else $error("request held after ack");
  AST_REQ_HOLD: assert property (irq_req.valid && !core_ack |=> irq_req.valid)
    else $error("request dropped before ack");
  AST_AT_BOUNDARY: assert property ($rose(irq_req.valid) |-> $past(instr_done))
    else $error("request not at instruction end");
  AST_VECTOR: assert property (irq_req.valid |-> irq_req.vector == {8'h00, irq_req.id, 3'h3})
    else $error("wrong vector");
  AST_ID_RANGE: assert property (irq_req.valid |-> irq_req.id <= 5'h16)
    else $error("source id out of range");
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_INTERRUPT_RETURN_WAIT: assert property (core_interrupt_return && !irq_req.valid |=> !irq_req.valid)
    else $error("request right after return");
  COV_CALL: cover property (core_ack);
  COV_HIGH: cover property (irq_req.valid && irq_req.high);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind vic_ctrl vic_asserts vic_asserts_inst (.clk(clk), .arst_n(arst_n), .instr_done(instr_done),
  .core_ack(core_ack), .core_interrupt_return(core_interrupt_return), .psel(psel), .penable(penable), .pready(pready),
  .irq_req(irq_req), .irq(irq));

// File: bench/vic_cpu.sv
`timescale 1ns/1ps
module vic_cpu (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire vic_pkg::vic_req_t irq_req,
  output logic                   instr_done,
  output logic                   core_ack,
  output logic                   core_interrupt_return,
  output logic [15:0]            last_vec,
  output int                     calls
);
  int busy;
  int service_routine;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {instr_done, core_ack, core_interrupt_return, last_vec} <= '0;
      busy <= 0;
      service_routine <= 0;
      calls <= 0;
    end
    else
    begin
      {instr_done, core_ack, core_interrupt_return} <= '0;
      if (busy > 0)
        busy <= busy - 1;
      else if (irq_req.valid)
      begin
        core_ack <= 1'b1;
        last_vec <= irq_req.vector;
        calls <= calls + 1;
        busy <= 3;
        service_routine <= 4;
      end
      else if (service_routine == 1)
      begin
        core_interrupt_return <= 1'b1;
        busy <= 4;
        service_routine <= 0;
      end
      else
      begin
        instr_done <= 1'b1;
        busy <= 1;
        service_routine <= service_routine - 1;
      end
    end
  end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic              clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic              instr_done, core_ack, core_interrupt_return;
  logic [22:0]       src_event;
  logic [31:0]       paddr, pwdata, prdata, rd;
  logic [15:0]       last_vec;
  vic_pkg::vic_req_t irq_req;
  int                calls, fail_count, checks;
  vic_ctrl vic_ctrl_inst (.clk(clk), .arst_n(arst_n), .src_event(src_event), .instr_done(instr_done),
    .core_ack(core_ack), .core_interrupt_return(core_interrupt_return), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq(irq));
  vic_cpu vic_cpu_inst (.clk(clk), .arst_n(arst_n), .irq_req(irq_req), .instr_done(instr_done),
    .core_ack(core_ack), .core_interrupt_return(core_interrupt_return), .last_vec(last_vec), .calls(calls));
  task end_of_test();
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data and error are taken only at the edge where pready is seen
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task ev(input logic [22:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= '0;
  endtask
  task wcall(input logic [15:0] v);
    int c0;
    c0 = calls;
    repeat (100) if (calls == c0) @(posedge clk);
    chk(calls > c0, 1);
    chk(last_vec, v);
  endtask
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {fail_count, checks} = '0;
    {arst_n, psel, penable, pwrite, paddr, pwdata, src_event} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, vic_pkg::APB_IRQ_ENA, 0);
    chk(rd, vic_pkg::ENA_RESET);
    apb(0, vic_pkg::APB_IRQ_PRIO, 0);
    chk(rd, vic_pkg::PRIO_RESET);
    apb(0, 32'h0000_0040, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, vic_pkg::APB_IRQ_ENA, 32'h0000_0004);
    ev(23'h000004);
    repeat (20) @(posedge clk);
    chk(calls, 0);
    apb(0, vic_pkg::APB_PEND, 0);
    chk(rd, 32'h0000_0004);
    apb(1, vic_pkg::APB_IRQ_ENA, 32'h0080_0004);
    wcall(16'h0013);
    apb(0, vic_pkg::APB_PEND, 0);
    chk(rd, 0);
    apb(1, vic_pkg::APB_IRQ_ENA, 32'h0080_0020);
    apb(1, vic_pkg::APB_PEND, 32'h0000_0020);
    wcall(16'h002B);
    wcall(16'h002B);
    apb(1, vic_pkg::APB_PEND, 0);
    repeat (30) @(posedge clk);
    apb(1, vic_pkg::APB_IRQ_PRIO, 32'h0010_0000);
    apb(1, vic_pkg::APB_IRQ_ENA, 32'h0090_0002);
    ev(23'h100002);
    wcall(16'h00A3);
    apb(1, vic_pkg::APB_PEND, 32'h0000_0002);
    repeat (40) @(posedge clk);
    chk(last_vec, 16'h000B);
    apb(1, vic_pkg::APB_IRQ_PRIO, 0);
    apb(1, vic_pkg::APB_IRQ_ENA, 32'h0080_0009);
    ev(23'h000009);
    wcall(16'h0003);
    wcall(16'h001B);
    apb(1, vic_pkg::APB_SUM_CLR, 32'h007F_FFFF);
    apb(1, vic_pkg::APB_SUM_EN, 32'h0000_0001);
    ev(23'h000001);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    apb(1, vic_pkg::APB_SUM_EN, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    apb(0, vic_pkg::APB_SUM_STAT, 0);
    chk(rd, 32'h0000_0001);
    end_of_test();
  end
endmodule
